// ### pwbcb_params.svh
// offsets, field positions, reset values and response codes of the bundle configuration bank
`ifndef PWBCB_PARAMS_SVH
`define PWBCB_PARAMS_SVH

// ---------------------------------------------------------------
// register blocks (byte base of each word group, bundle n at base + 4*n)
// ---------------------------------------------------------------
`define PWBCB_RXID_BASE      12'h000
`define PWBCB_BUFHDR_BASE    12'h100
`define PWBCB_TXPAY_BASE     12'h200
`define PWBCB_SEL_OFS        12'h300
`define PWBCB_STAT_OFS       12'h304

// ---------------------------------------------------------------
// buffer / header word fields
// ---------------------------------------------------------------
`define PWBCB_JB_MSB         31
`define PWBCB_JB_LSB         22
`define PWBCB_PM_MSB         21
`define PWBCB_PM_LSB         20
`define PWBCB_RTP_BIT        19
`define PWBCB_CW_BIT         18
`define PWBCB_DST_MSB        17
`define PWBCB_DST_LSB        16
`define PWBCB_LOST_MSB       15
`define PWBCB_LOST_LSB       9
`define PWBCB_TS_MSB         8
`define PWBCB_TS_LSB         4
`define PWBCB_SAN_BIT        3
`define PWBCB_HDR_MSB        2
`define PWBCB_HDR_LSB        1
`define PWBCB_RBIT_BIT       0

// ---------------------------------------------------------------
// transmit payload word fields
// ---------------------------------------------------------------
`define PWBCB_COND_BIT       30
`define PWBCB_FRM_BIT        29
`define PWBCB_CAS_BIT        28
`define PWBCB_PLEN_MSB       26
`define PWBCB_PLEN_LSB       16
`define PWBCB_OCT_MSB        5
`define PWBCB_OCT_LSB        4
`define PWBCB_RSV_MASK       32'h8800_0000

// ---------------------------------------------------------------
// reset values and answers
// ---------------------------------------------------------------
`define PWBCB_SEL_RST        6'h00
`define PWBCB_WORD_RST       32'h0000_0000
`define PWBCB_RESP_OKAY      2'h0
`define PWBCB_RESP_SLVERR    2'h2
`define PWBCB_PM_SATOP       2'h3
`define PWBCB_DST_RSV        2'h0

`endif

// ### pwbcb_pkg.sv
// types shared by the bundle configuration bank
package pwbcb_pkg;
    // payload engine selection
    typedef enum logic [1:0] {
        PWBCB_PM_HDLC  = 2'h0,
        PWBCB_PM_AAL1  = 2'h1,
        PWBCB_PM_RSV   = 2'h2,
        PWBCB_PM_CE    = 2'h3
    } pwbcb_pm_t;

    // transmit destination
    typedef enum logic [1:0] {
        PWBCB_DST_NONE = 2'h0,
        PWBCB_DST_ETH  = 2'h1,
        PWBCB_DST_CPU  = 2'h2,
        PWBCB_DST_XC   = 2'h3
    } pwbcb_dst_t;

    // encapsulation
    typedef enum logic [1:0] {
        PWBCB_HDR_MPLS = 2'h0,
        PWBCB_HDR_UDP  = 2'h1,
        PWBCB_HDR_L2TP = 2'h2,
        PWBCB_HDR_MEF  = 2'h3
    } pwbcb_hdr_t;

    // decoded configuration of one bundle
    typedef struct packed {
        logic [31:0] rx_identifier;
        logic [9:0]  jitter_buffer_size;
        pwbcb_pm_t   payload_machine;
        logic        transmit_rtp_header_on;
        logic        control_word_present;
        pwbcb_dst_t  tx_destination;
        logic [6:0]  max_lost_packets;
        logic [4:0]  timeslot_count_minus_one;
        logic        sanity_discard;
        pwbcb_hdr_t  header_type;
        logic        tx_r_bit;
        logic        tx_conditioning;
        logic        dest_esf_framing;
        logic        cas_from_table;
        logic [10:0] payload_length;
        logic [1:0]  cond_octet_sel;
    } pwbcb_cfg_t;

    // per-engine routing strobes
    typedef struct packed {
        logic hdlc;
        logic aal1;
        logic ce;
    } pwbcb_route_t;

    // slave access states
    typedef enum logic [1:0] {
        PWBCB_IDLE  = 2'b00,
        PWBCB_WRESP = 2'b01,
        PWBCB_RRESP = 2'b11
    } pwbcb_state_t;
endpackage

// ### pwbcb_field_unpack.sv
// unpacks three bundle words into a decoded configuration
`timescale 1ns/1ps
`include "pwbcb_params.svh"
module pwbcb_field_unpack (
    // raw words
    input  wire logic [31:0]         word_rx_id,
    input  wire logic [31:0]         word_buf_hdr,
    input  wire logic [31:0]         word_tx_pay,
    // decoded result
    output pwbcb_pkg::pwbcb_cfg_t    cfg
);
    import pwbcb_pkg::*;

    // field slicing of the three words
    always_comb begin
        cfg                          = '0;
        cfg.rx_identifier            = word_rx_id;                                     // [RL2]
        cfg.jitter_buffer_size       = word_buf_hdr[`PWBCB_JB_MSB:`PWBCB_JB_LSB];     // [RL3]
        cfg.payload_machine          = pwbcb_pm_t'(word_buf_hdr[`PWBCB_PM_MSB:`PWBCB_PM_LSB]);
        cfg.transmit_rtp_header_on   = word_buf_hdr[`PWBCB_RTP_BIT];                  // [RL7]
        cfg.control_word_present     = word_buf_hdr[`PWBCB_CW_BIT];                   // [RL8]
        cfg.tx_destination           = pwbcb_dst_t'(word_buf_hdr[`PWBCB_DST_MSB:`PWBCB_DST_LSB]);
        cfg.max_lost_packets         = word_buf_hdr[`PWBCB_LOST_MSB:`PWBCB_LOST_LSB]; // [RL10]
        cfg.timeslot_count_minus_one = word_buf_hdr[`PWBCB_TS_MSB:`PWBCB_TS_LSB];     // [RL11]
        cfg.sanity_discard           = word_buf_hdr[`PWBCB_SAN_BIT];                  // [RL12]
        cfg.header_type              = pwbcb_hdr_t'(word_buf_hdr[`PWBCB_HDR_MSB:`PWBCB_HDR_LSB]);
        cfg.tx_r_bit                 = word_buf_hdr[`PWBCB_RBIT_BIT];                 // [RL14]
        cfg.tx_conditioning          = word_tx_pay[`PWBCB_COND_BIT];                  // [RL15]
        cfg.dest_esf_framing         = word_tx_pay[`PWBCB_FRM_BIT];                   // [RL16]
        cfg.cas_from_table           = word_tx_pay[`PWBCB_CAS_BIT];                   // [RL17]
        cfg.payload_length           = word_tx_pay[`PWBCB_PLEN_MSB:`PWBCB_PLEN_LSB];  // [RL18]
        cfg.cond_octet_sel           = word_tx_pay[`PWBCB_OCT_MSB:`PWBCB_OCT_LSB];    // [RL21]
    end
endmodule

// ### pwbcb_config_bank.sv
// per-bundle configuration store with an axi4-lite register slave
// ---------------------------------------------------------------
// Behaviour
// RL1 - sixty-four bundles, word at base plus 4n
// RL2 - first word holds 32-bit receive identifier
// RL3 - 10-bit jitter buffer size field
// RL4 - software caps buffer size per framing
// RL5 - software keeps buffer above threshold plus build
// RL6 - payload machine field routes bundle engine
// RL7 - rtp bit adds rtp header
// RL8 - control word present bit
// RL9 - destination field steers packets, 00 reserved
// RL10 - lost packet insertion limited by field
// RL11 - timeslot count ignored unstructured or high-speed
// RL12 - sanity discard bit drops failing packets
// RL13 - header type selects encapsulation
// RL14 - r bit zero leaves r clear
// RL15 - conditioning bit fills with selected octet
// RL16 - destination framing bit: sf or esf
// RL17 - cas source bit: input pin or table
// RL18 - payload length frames or bytes per packet
// RL19 - software writes zero to reserved bits
// RL20 - software keeps delay threshold at least three
// RL21 - octet selector picks conditioning octet a-d
// RL22 - software programs all fields before traffic
// ---------------------------------------------------------------
`timescale 1ns/1ps
`include "pwbcb_params.svh"
module pwbcb_config_bank #(
    parameter int NUM_BUNDLES = 64
) (
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // axi4-lite write address and data
    input  wire logic [11:0]            s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // axi4-lite read
    input  wire logic [11:0]            s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // datapath lookup of one bundle
    input  wire logic [5:0]             lookup_bundle,
    output pwbcb_pkg::pwbcb_cfg_t       lookup_cfg_ff,
    output pwbcb_pkg::pwbcb_route_t     lookup_route_ff,
    // conditioning octets and the octet they select
    input  wire logic [31:0]            cond_octets,
    output logic [7:0]                  cond_octet_ff,
    // lost packet insertion credit
    input  wire logic                   lost_detect,
    output logic                        lost_insert,
    // ce sanity check outcome
    input  wire logic                   rx_sanity_fail,
    output logic                        rx_drop
);
    import pwbcb_pkg::*;

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    // cleared at reset so the lookup outputs never carry unknowns; software still sets all
    logic [31:0]  rxid_mem   [NUM_BUNDLES];
    logic [31:0]  bufhdr_mem [NUM_BUNDLES];
    logic [31:0]  txpay_mem  [NUM_BUNDLES];
    pwbcb_state_t state_ff;
    logic [11:0]  waddr_ff;
    logic [31:0]  wdata_ff;
    logic [3:0]   wstrb_ff;
    logic         aw_have_ff;
    logic         w_have_ff;
    logic [5:0]   sel_ff;
    logic [6:0]   lost_cnt_ff;
    logic [5:0]   lk_idx_ff;
    logic         wr_err_ff;
    pwbcb_cfg_t   lk_cfg;
    pwbcb_cfg_t   sel_cfg;

    // ---------------------------------------------------------------
    // address decode helpers
    // ---------------------------------------------------------------
    // returns the word group (0..2) of a byte address, 3 when not an array word
    function automatic logic [1:0] grp_of(input logic [11:0] a);
        if (a < `PWBCB_BUFHDR_BASE) begin
            grp_of = 2'h0;
        end else if (a < `PWBCB_TXPAY_BASE) begin
            grp_of = 2'h1;
        end else if (a < `PWBCB_SEL_OFS) begin
            grp_of = 2'h2;
        end else begin
            grp_of = 2'h3;
        end
    endfunction

    // bundle index from address bits: word n sits at base + 4n
    function automatic logic [5:0] idx_of(input logic [11:0] a);
        idx_of = a[7:2]; // [RL1]
    endfunction

    // merges byte lanes of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                merge[i*8 +: 8] = d[i*8 +: 8];
            end
        end
    endfunction

    logic [1:0] w_grp;
    logic [5:0] w_idx;
    logic       w_fire;
    logic       w_bad;
    logic [1:0] r_grp;
    logic [5:0] r_idx;
    logic       r_fire;
    assign w_grp  = grp_of(waddr_ff);
    assign w_idx  = idx_of(waddr_ff);
    assign w_fire = (state_ff == PWBCB_IDLE) && aw_have_ff && w_have_ff;
    assign w_bad  = (w_grp == 2'h3) && (waddr_ff != `PWBCB_SEL_OFS);
    assign r_grp  = grp_of(s_axi_araddr);
    assign r_idx  = idx_of(s_axi_araddr);
    // writes win over reads when both are pending
    assign r_fire = (state_ff == PWBCB_IDLE) && s_axi_arvalid && !(aw_have_ff && w_have_ff);

    // ---------------------------------------------------------------
    // write address and data capture, taken in either order
    // ---------------------------------------------------------------
    assign s_axi_awready = !aw_have_ff && (state_ff == PWBCB_IDLE);
    assign s_axi_wready  = !w_have_ff && (state_ff == PWBCB_IDLE);
    // address holding register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            waddr_ff   <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_ff <= 1'b1;
            waddr_ff   <= {s_axi_awaddr[11:2], 2'b00};
        end else if (w_fire) begin
            aw_have_ff <= 1'b0;
        end
    end

    // data holding register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_ff <= 1'b0;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
        end else if (w_fire) begin
            w_have_ff <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // array writes
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_BUNDLES; i++) begin
                rxid_mem[i]   <= `PWBCB_WORD_RST;
                bufhdr_mem[i] <= `PWBCB_WORD_RST;
                txpay_mem[i]  <= `PWBCB_WORD_RST;
            end
        end else if (w_fire) begin
            if (w_grp == 2'h0) begin
                rxid_mem[w_idx] <= merge(rxid_mem[w_idx], wdata_ff, wstrb_ff); // [RL2]
            end else if (w_grp == 2'h1) begin
                bufhdr_mem[w_idx] <= merge(bufhdr_mem[w_idx], wdata_ff, wstrb_ff);
            end else if (w_grp == 2'h2) begin
                // reserved bits are stored as written; software keeps them zero
                txpay_mem[w_idx] <= merge(txpay_mem[w_idx], wdata_ff, wstrb_ff); // [RL19]
            end
        end
    end

    // bundle selector, read back at the selector offset and decoded only for the c_sel_match cover
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_ff <= `PWBCB_SEL_RST;
        end else if (w_fire && (waddr_ff == `PWBCB_SEL_OFS) && wstrb_ff[0]) begin
            sel_ff <= wdata_ff[5:0];
        end
    end

    // ---------------------------------------------------------------
    // access state machine and responses
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff  <= PWBCB_IDLE;
            wr_err_ff <= 1'b0;
        end else begin
            case (state_ff)
                PWBCB_IDLE: begin
                    if (w_fire) begin
                        state_ff  <= PWBCB_WRESP;
                        wr_err_ff <= w_bad;
                    end else if (r_fire) begin
                        state_ff <= PWBCB_RRESP;
                    end
                end
                PWBCB_WRESP: begin
                    if (s_axi_bready) begin
                        state_ff <= PWBCB_IDLE;
                    end
                end
                PWBCB_RRESP: begin
                    if (s_axi_rready) begin
                        state_ff <= PWBCB_IDLE;
                    end
                end
                default: begin
                    state_ff <= PWBCB_IDLE;
                end
            endcase
        end
    end

    assign s_axi_bvalid  = (state_ff == PWBCB_WRESP);
    assign s_axi_bresp   = wr_err_ff ? `PWBCB_RESP_SLVERR : `PWBCB_RESP_OKAY;
    assign s_axi_arready = r_fire;
    assign s_axi_rvalid  = (state_ff == PWBCB_RRESP);
    // read data register, loaded when the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PWBCB_RESP_OKAY;
        end else if (r_fire) begin
            s_axi_rresp <= `PWBCB_RESP_OKAY;
            if (r_grp == 2'h0) begin
                s_axi_rdata <= rxid_mem[r_idx];
            end else if (r_grp == 2'h1) begin
                s_axi_rdata <= bufhdr_mem[r_idx];
            end else if (r_grp == 2'h2) begin
                s_axi_rdata <= txpay_mem[r_idx];
            end else if (s_axi_araddr[11:2] == `PWBCB_SEL_OFS >> 2) begin
                s_axi_rdata <= {26'h0, sel_ff};
            end else if (s_axi_araddr[11:2] == `PWBCB_STAT_OFS >> 2) begin
                // live state: lost credit used on the lookup bundle and its route
                s_axi_rdata <= {14'h0, lookup_route_ff, 2'h0, lost_cnt_ff, lk_idx_ff};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `PWBCB_RESP_SLVERR;
            end
        end
    end

    // ---------------------------------------------------------------
    // datapath lookup
    // ---------------------------------------------------------------
    pwbcb_field_unpack u_unpack (
        .word_rx_id   (rxid_mem[lookup_bundle]),
        .word_buf_hdr (bufhdr_mem[lookup_bundle]),
        .word_tx_pay  (txpay_mem[lookup_bundle]),
        .cfg          (lk_cfg)
    );

    // decodes the selected bundle; used only by the c_sel_match cover, not by any readback
    pwbcb_field_unpack u_unpack_sel (
        .word_rx_id   (rxid_mem[sel_ff]),
        .word_buf_hdr (bufhdr_mem[sel_ff]),
        .word_tx_pay  (txpay_mem[sel_ff]),
        .cfg          (sel_cfg)
    );

    // registered configuration with engine routing; reserved engine code routes nowhere, other fields pass unchanged
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lookup_cfg_ff   <= '0;
            lookup_route_ff <= '0;
            lk_idx_ff       <= 6'h00;
        end else begin
            lookup_cfg_ff   <= lk_cfg; // [RL9] [RL13] [RL14]
            lk_idx_ff       <= lookup_bundle;
            lookup_route_ff.hdlc <= (lk_cfg.payload_machine == PWBCB_PM_HDLC);  // [RL6]
            lookup_route_ff.aal1 <= (lk_cfg.payload_machine == PWBCB_PM_AAL1);  // [RL6]
            lookup_route_ff.ce   <= (lk_cfg.payload_machine == PWBCB_PM_CE);    // [RL6]
        end
    end

    // conditioning octet chosen by the selector
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cond_octet_ff <= 8'h00;
        end else begin
            cond_octet_ff <= cond_octets[lk_cfg.cond_octet_sel*8 +: 8]; // [RL21] [RL15]
        end
    end

    // ---------------------------------------------------------------
    // lost packet insertion credit, restarted when the lookup bundle changes
    // ---------------------------------------------------------------
    assign lost_insert = lost_detect && (lost_cnt_ff < lookup_cfg_ff.max_lost_packets); // [RL10]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lost_cnt_ff <= 7'h00;
        end else if (lk_idx_ff != lookup_bundle) begin
            lost_cnt_ff <= 7'h00;
        end else if (lost_insert) begin
            lost_cnt_ff <= lost_cnt_ff + 7'h01; // [RL10]
        end else if (!lost_detect) begin
            lost_cnt_ff <= 7'h00;
        end
    end

    // sanity failures are dropped only when the bundle asks for it
    assign rx_drop = rx_sanity_fail && lookup_cfg_ff.sanity_discard
                     && lookup_route_ff.ce; // [RL12]

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_route_onehot: assert property (@(posedge aclk) disable iff (!aresetn) // [RL6]
        $onehot0(lookup_route_ff))
        else $error("engine route not one-hot");
    a_route_ce: assert property (@(posedge aclk) disable iff (!aresetn) // [RL6]
        lookup_route_ff.ce |-> lookup_cfg_ff.payload_machine == PWBCB_PM_CE)
        else $error("ce route without ce machine");
    a_lost_limit: assert property (@(posedge aclk) disable iff (!aresetn) // [RL10]
        lost_insert |-> lost_cnt_ff < lookup_cfg_ff.max_lost_packets)
        else $error("lost insertion above limit");
    a_drop_cause: assert property (@(posedge aclk) disable iff (!aresetn) // [RL12]
        rx_drop |-> rx_sanity_fail && lookup_cfg_ff.sanity_discard)
        else $error("drop without discard enable");
    a_rdata_word: assert property (@(posedge aclk) disable iff (!aresetn) // [RL1]
        (r_fire && r_grp == 2'h0) |=> s_axi_rvalid && s_axi_rdata == $past(rxid_mem[r_idx]))
        else $error("identifier readback mismatch");
    a_write_store: assert property (@(posedge aclk) disable iff (!aresetn) // [RL2]
        (w_fire && w_grp == 2'h0 && wstrb_ff == 4'hF) |=> rxid_mem[$past(w_idx)] == $past(wdata_ff))
        else $error("identifier write lost");
    a_rtp_follow: assert property (@(posedge aclk) disable iff (!aresetn) // [RL7]
        $past(aresetn) && !$past(w_fire) |-> lookup_cfg_ff.transmit_rtp_header_on
            == bufhdr_mem[lk_idx_ff][`PWBCB_RTP_BIT]) else $error("rtp flag not from word");
    a_oct_select: assert property (@(posedge aclk) disable iff (!aresetn) // [RL21]
        $past(aresetn) |-> cond_octet_ff
            == 8'($past(cond_octets) >> {lookup_cfg_ff.cond_octet_sel, 3'h0}))
        else $error("wrong conditioning octet");
    a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    c_write_done: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready);
    c_read_done:  cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready);
    c_lost_cap:   cover property (@(posedge aclk) disable iff (!aresetn)
        lost_detect && !lost_insert);
    c_sel_match:  cover property (@(posedge aclk) disable iff (!aresetn)
        sel_cfg.payload_machine == PWBCB_PM_CE);
endmodule

// ### pwbcb_config_bank_test.sv
// self-checking bench for the bundle configuration bank
`timescale 1ns/1ps
`include "pwbcb_params.svh"
module pwbcb_config_bank_test;
    import pwbcb_pkg::*;
    logic          aclk = 0, aresetn = 0, lost_detect = 0, rx_sanity_fail = 1;
    logic [11:0]   s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0]   s_axi_wdata = 0, cond_octets = 32'hDDCC_BBAA, s_axi_rdata, rdv;
    logic [3:0]    s_axi_wstrb = 4'hF;
    logic          s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic          s_axi_bready = 1, s_axi_rready = 1; // always ready: no back-pressure
    logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic          s_axi_rvalid, lost_insert, rx_drop;
    logic [1:0]    s_axi_bresp, s_axi_rresp, rs;
    logic [5:0]    lookup_bundle = 0;
    logic [7:0]    cond_octet_ff;
    pwbcb_cfg_t    lookup_cfg_ff;
    pwbcb_route_t  lookup_route_ff;
    int            error_cnt = 0, tests_run = 0, cyc = 0, n;

    always #2 aclk = ~aclk;

    pwbcb_config_bank dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lookup_bundle,
        .lookup_cfg_ff, .lookup_route_ff, .cond_octets, .cond_octet_ff, .lost_detect,
        .lost_insert, .rx_sanity_fail, .rx_drop);

    // compare and count
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // write: address and data offered together, each dropped once taken
    task wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
    endtask

    // read: data and response taken at the rvalid edge
    task rd(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rdv = s_axi_rdata;
        rs = s_axi_rresp;
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // hang guard: whole run needs well under a thousand cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            close_out;
        end
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        wr(12'h000, 32'hA5A5_0001);
        wr(12'h0FC, 32'h5A5A_003F);
        rd(12'h000);
        chk(rdv, 32'hA5A5_0001);
        rd(12'h0FC);
        chk(rdv, 32'h5A5A_003F);
        $display("test storage done");
        // every code of engine, destination, header and octet selector on bundle 6
        lookup_bundle <= 6'd6;
        wr(12'h018, 32'h0000_0006);
        for (n = 0; n < 4; n++) begin
            // buffer 0x2F0: under every framing cap, above threshold plus build time
            wr(12'h118, (n << 20) | (n << 16) | (n << 1) | 32'hBC00_0408);
            wr(12'h218, ((n + 1) << 16) | (n << 4) | 32'h1000_0000);
            repeat (3) @(posedge aclk);
            chk(rs, `PWBCB_RESP_OKAY);
            chk(lookup_cfg_ff.rx_identifier, 32'h6);
            chk(32'(lookup_cfg_ff.jitter_buffer_size), 32'h2F0);
            chk(32'(lookup_cfg_ff.max_lost_packets), 2);
            chk(32'(lookup_route_ff), {29'h0, n == 0, n == 1, n == 3});
            chk(32'(lookup_cfg_ff.tx_destination), n);
            chk(32'(lookup_cfg_ff.header_type), n);
            chk(32'(cond_octet_ff), (32'hDDCC_BBAA >> (8 * n)) & 32'hFF);
            chk(32'(lookup_cfg_ff.cas_from_table), 1);
            chk(32'(lookup_cfg_ff.payload_length), n + 1);
            chk(32'(rx_drop), n == 3);
        end
        $display("test decode done");
        // insertion credit of two lost packets
        lost_detect <= 1'b1;
        n = 0;
        repeat (8) begin
            @(posedge aclk);
            if (lost_insert === 1'b1) n++;
        end
        chk(n, 2);
        lost_detect <= 1'b0;
        $display("test lost credit done");
        wr(`PWBCB_SEL_OFS, 32'h6);
        rd(`PWBCB_SEL_OFS);
        chk(rdv, 32'h6);
        rd(`PWBCB_STAT_OFS);
        chk(rdv, 32'h0000_8006);
        rd(12'h218);
        chk(rdv, 32'h1004_0030);
        rd(12'h308);
        chk(rs, `PWBCB_RESP_SLVERR);
        chk(rdv, 32'h0);
        wr(`PWBCB_STAT_OFS, 32'h1);
        chk(rs, `PWBCB_RESP_SLVERR);
        $display("test unmapped done");
        close_out;
    end
endmodule
